//--- logic/rcsfc_ctrl.sv
// Clock source selection, fast RC postscaler and fail-safe monitor, APB register slave.
// Assumes oscillator events arrive as single-cycle pulses synchronous to clk.
// Function
// - Fast RC drives system clock for current source codes 111, 001, 000.
// - Fast RC on at power-on; after timer expiry only when it is the current or the requested next source.
// - Postscaler chosen by three-bit divide select in divider register bits 10:8.
// - Code 111 applies postscaler output as system clock.
// - Code 001 is fast RC with PLL, works only for select 000/001.
// - Basic 4x PLL gives nominal 16 or 32 MHz from postscaler.
// - USB PLL variant also makes 48 MHz USB clock, not advised.
// - Slow RC at 31 kHz clocks power-up timer, watchdog and monitor.
// - Slow RC on at power-on without regulator; later only if needed.
// - Monitor enabled only for config 00; then slow RC runs except sleep.
// - Failure raises trap, loads code 000, sets fail flag, clears request.
// - Monitor supervises whichever source currently drives the system clock.
// - Start delay after a reset event only (wake from sleep goes straight to watch), only for external, high-speed or secondary.
// - Delay expiring before oscillator starts raises trap and selects fast RC.
// - Clock failure leaves watchdog running on slow RC.
// - Software switches only among sources; submode fixed by configuration.
// - Switching enabled only when switch-enable bit is 0; 1 disables monitor.
// - Switching disabled: next source ignored, current shows initial configuration.
// - Switching disabled: request bit has no effect, reads zero.
// - Request with next equal current is redundant, cleared and aborted.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module rcsfc_ctrl
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rcsfc_pkg::rcsfc_cfg_t cfg,
    input wire logic power_up_timer_done,
    input wire logic internal_system_reset,
    input wire logic reset_event,
    input wire logic sleep,
    input wire logic slow_rc_tick,
    input wire logic sys_clk_edge,
    input wire logic source_ready,
    input wire logic pll_lock,
    output logic [2:0] sys_clk_sel,
    output logic [3:0] postscale_shift,
    output logic [15:0] sys_clk_nominal_khz,
    output logic fast_rc_enable,
    output logic slow_rc_enable,
    output logic pll_enable,
    output logic usb_clk_enable,
    output logic clock_fail_trap
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] div_shift(input logic [2:0] sel);
        div_shift = (sel == 3'h7) ? 4'h8 : {1'b0, sel};
    endfunction : div_shift

    function automatic logic is_fast_rc(input logic [2:0] src);
        is_fast_rc = (src == rcsfc_pkg::SRC_FAST_RC) || (src == rcsfc_pkg::SRC_FAST_RC_PLL)
            || (src == rcsfc_pkg::SRC_FAST_RC_DIV);
    endfunction : is_fast_rc

    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == rcsfc_pkg::SRC_FAST_RC_PLL) || (src == rcsfc_pkg::SRC_PRIMARY_PLL);
    endfunction : uses_pll

    rcsfc_pkg::rcsfc_state_t s;
    rcsfc_pkg::rcsfc_state_t next_s;
    logic switch_en;
    logic mon_en;
    logic needs_delay;
    logic wr;
    logic setup;
    logic fail;

    assign switch_en = ~cfg.switch_monitor_config[1];
    assign mon_en = (cfg.switch_monitor_config == 2'h0);
    assign needs_delay = (s.cur_src == rcsfc_pkg::SRC_SECONDARY)
        || (((s.cur_src == rcsfc_pkg::SRC_PRIMARY) || (s.cur_src == rcsfc_pkg::SRC_PRIMARY_PLL))
        && ((cfg.primary_submode_config == rcsfc_pkg::SUB_EXT_CLOCK)
        || (cfg.primary_submode_config == rcsfc_pkg::SUB_HIGH_XTAL)));
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.trap = 1'b0;
        fail = 1'b0;
        // Register read data captured in the setup cycle
        if (setup)
        begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
            if (paddr == rcsfc_pkg::OSC_CTRL_ADDR)
            begin
                next_s.prdata[rcsfc_pkg::CUR_SRC_LSB +: 3] = s.cur_src;
                next_s.prdata[rcsfc_pkg::NXT_SRC_LSB +: 3] = s.nxt_src;
                next_s.prdata[rcsfc_pkg::FAIL_FLAG_BIT] = s.fail_flag;
                next_s.prdata[rcsfc_pkg::SW_REQ_BIT] = s.sw_req;
            end
            else if (paddr == rcsfc_pkg::CLK_DIV_ADDR)
            begin
                next_s.prdata[rcsfc_pkg::DIV_SEL_LSB +: 3] = s.div_sel;
            end
            else
            begin
                next_s.pslverr = 1'b1;
            end
        end
        // Software writes
        if (wr && (paddr == rcsfc_pkg::OSC_CTRL_ADDR))
        begin
            if (switch_en)
            begin
                next_s.nxt_src = pwdata[rcsfc_pkg::NXT_SRC_LSB +: 3];
                next_s.sw_req = pwdata[rcsfc_pkg::SW_REQ_BIT];
            end
            if (!pwdata[rcsfc_pkg::FAIL_FLAG_BIT])
            begin
                next_s.fail_flag = 1'b0;
            end
        end
        if (wr && (paddr == rcsfc_pkg::CLK_DIV_ADDR))
        begin
            next_s.div_sel = pwdata[rcsfc_pkg::DIV_SEL_LSB +: 3];
        end
        // Switch engine
        if (!switch_en)
        begin
            next_s.cur_src = cfg.initial_source_config;
            next_s.sw_req = 1'b0;
        end
        else if (!s.init_done)
        begin
            next_s.cur_src = cfg.initial_source_config;
            next_s.init_done = 1'b1;
        end
        else if (s.sw_req && sleep)
        begin
            next_s.sw_req = 1'b0;
        end
        else if (s.sw_req && (s.nxt_src == s.cur_src))
        begin
            next_s.sw_req = 1'b0;
        end
        else if (s.sw_req && source_ready && (!uses_pll(s.nxt_src) || pll_lock))
        begin
            next_s.cur_src = s.nxt_src;
            next_s.sw_req = 1'b0;
        end
        // Fail-safe monitor
        if (!mon_en || sleep)
        begin
            next_s.mon = rcsfc_pkg::MON_IDLE;
        end
        if (mon_en && reset_event)
        begin
            next_s.mon = rcsfc_pkg::MON_HOLD;
            next_s.tick_cnt = 7'h00;
        end
        else if (mon_en && !sleep)
        begin
            case (s.mon)
                rcsfc_pkg::MON_IDLE:
                begin
                    next_s.mon = rcsfc_pkg::MON_WATCH;
                    next_s.tick_cnt = 7'h00;
                    next_s.edge_seen = 1'b0;
                end
                rcsfc_pkg::MON_HOLD:
                begin
                    if (!internal_system_reset)
                    begin
                        next_s.mon = needs_delay ? rcsfc_pkg::MON_DELAY : rcsfc_pkg::MON_WATCH;
                        next_s.tick_cnt = 7'h00;
                        next_s.edge_seen = 1'b0;
                    end
                end
                rcsfc_pkg::MON_DELAY:
                begin
                    if (slow_rc_tick)
                    begin
                        next_s.tick_cnt = s.tick_cnt + 7'h01;
                        if (s.tick_cnt == rcsfc_pkg::START_DELAY_TICKS - 7'h01)
                        begin
                            fail = ~source_ready;
                            next_s.mon = rcsfc_pkg::MON_WATCH;
                            next_s.tick_cnt = 7'h00;
                            next_s.edge_seen = 1'b0;
                        end
                    end
                end
                rcsfc_pkg::MON_WATCH:
                begin
                    // Edges of whatever source is current
                    next_s.edge_seen = s.edge_seen | sys_clk_edge;
                    if (slow_rc_tick)
                    begin
                        next_s.tick_cnt = s.tick_cnt + 7'h01;
                        if (s.tick_cnt == rcsfc_pkg::WINDOW_TICKS - 7'h01)
                        begin
                            fail = ~(s.edge_seen | sys_clk_edge);
                            next_s.tick_cnt = 7'h00;
                            next_s.edge_seen = 1'b0;
                        end
                    end
                end
                default:
                begin
                    next_s.mon = rcsfc_pkg::MON_IDLE;
                end
            endcase
        end
        // Failure overrides switching and the flag clear
        if (fail)
        begin
            next_s.trap = 1'b1;
            next_s.cur_src = rcsfc_pkg::SRC_FAST_RC;
            next_s.fail_flag = 1'b1;
            next_s.sw_req = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s <= '{cur_src: rcsfc_pkg::SRC_FAST_RC, nxt_src: rcsfc_pkg::SRC_FAST_RC,
                   div_sel: rcsfc_pkg::DIV_SEL_RESET, mon: rcsfc_pkg::MON_IDLE,
                   tick_cnt: 7'h00, prdata: 32'h0000_0000, default: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s.prdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & s.pslverr;
    assign sys_clk_sel = s.cur_src;
    assign clock_fail_trap = s.trap;
    // Full postscaler in divided mode; PLL mode takes select bit 0 only (000/001)
    assign postscale_shift = (s.cur_src == rcsfc_pkg::SRC_FAST_RC_DIV) ? div_shift(s.div_sel)
        : (s.cur_src == rcsfc_pkg::SRC_FAST_RC_PLL) ? {3'h0, s.div_sel[0]} : 4'h0;
    assign pll_enable = (s.cur_src == rcsfc_pkg::SRC_PRIMARY_PLL)
        || ((s.cur_src == rcsfc_pkg::SRC_FAST_RC_PLL) && (s.div_sel[2:1] == 2'h0));
    assign usb_clk_enable = rcsfc_pkg::HAS_USB_PLL & pll_enable;
    assign sys_clk_nominal_khz = !is_fast_rc(s.cur_src) ? 16'h0000
        : (s.cur_src == rcsfc_pkg::SRC_FAST_RC_PLL)
        ? (pll_enable ? 16'((rcsfc_pkg::FAST_RC_KHZ << rcsfc_pkg::PLL_MULT_SHIFT)
        >> postscale_shift) : 16'h0000)
        : 16'(rcsfc_pkg::FAST_RC_KHZ >> postscale_shift);
    assign fast_rc_enable = ~power_up_timer_done | is_fast_rc(s.cur_src)
        | (s.sw_req & is_fast_rc(s.nxt_src));
    // Watchdog term ignores failure state
    assign slow_rc_enable = power_up_timer_done
        ? ((mon_en & ~sleep) | cfg.wdt_enable | (s.cur_src == rcsfc_pkg::SRC_SLOW_RC))
        : cfg.regulator_disable;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_fail_loads_fast: assert property (clock_fail_trap |-> sys_clk_sel == 3'h0 && !s.sw_req)
        else $error("Failure did not select fast RC");
    a_fail_sets_flag: assert property ($rose(clock_fail_trap) |-> s.fail_flag)
        else $error("Fail flag not set with trap");
    a_req_held_zero: assert property (!switch_en |=> !s.sw_req)
        else $error("Request bit set while switching disabled");
    a_cur_tracks_cfg: assert property (!switch_en && $stable(cfg.initial_source_config)
        |=> sys_clk_sel == cfg.initial_source_config)
        else $error("Current source not from initial configuration");
    a_redundant_abort: assert property (s.sw_req && s.init_done && switch_en
        && s.nxt_src == s.cur_src && !fail |=> !s.sw_req && $stable(sys_clk_sel))
        else $error("Redundant switch not aborted");
    a_no_trap_off: assert property (!mon_en |=> !clock_fail_trap)
        else $error("Trap while monitor disabled");
    a_fast_rc_on: assert property (is_fast_rc(sys_clk_sel) |-> fast_rc_enable)
        else $error("Fast RC off while selected");
    a_pll_gating: assert property (sys_clk_sel == 3'h1 && s.div_sel[2:1] != 2'h0 |-> !pll_enable)
        else $error("PLL on with bad divide select");
    a_wdt_slow_rc: assert property (cfg.wdt_enable && power_up_timer_done |-> slow_rc_enable)
        else $error("Watchdog lost slow RC");
    a_delay_no_trap: assert property (s.mon == rcsfc_pkg::MON_DELAY && !slow_rc_tick
        |=> !clock_fail_trap)
        else $error("Trap during start delay without tick");
    a_div_256: assert property (sys_clk_sel == 3'h7 && s.div_sel == 3'h7
        |-> postscale_shift == 4'h8)
        else $error("Divide by 256 wrong");

    c_watch_fail: cover property (s.mon == rcsfc_pkg::MON_WATCH ##1 clock_fail_trap);
    c_delay_fail: cover property (s.mon == rcsfc_pkg::MON_DELAY ##1 clock_fail_trap);
    c_switch_done: cover property (s.sw_req ##1 !s.sw_req && $changed(sys_clk_sel));
    c_pll_mode: cover property (pll_enable && sys_clk_sel == 3'h1);
endmodule : rcsfc_ctrl

//--- logic/rcsfc_pkg.sv
// Constants, register layout and state types for the fast/slow RC clock controller.
// Assumes one 100 MHz register clock and a synchronous active-high reset.
package rcsfc_pkg;
    // ----------------------------------------
    // Register map (byte addresses, one word each)
    // ----------------------------------------
    localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] CLK_DIV_ADDR = 12'h004;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CUR_SRC_LSB = 12;
    localparam int NXT_SRC_LSB = 8;
    localparam int FAIL_FLAG_BIT = 3;
    localparam int SW_REQ_BIT = 0;
    localparam int DIV_SEL_LSB = 8;
    // ----------------------------------------
    // Source codes
    // ----------------------------------------
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] SRC_SLOW_RC = 3'h4;
    localparam logic [2:0] SRC_SECONDARY = 3'h5;
    localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;
    // Primary submode codes
    localparam logic [1:0] SUB_EXT_CLOCK = 2'h0;
    localparam logic [1:0] SUB_LOW_XTAL = 2'h1;
    localparam logic [1:0] SUB_HIGH_XTAL = 2'h2;
    // ----------------------------------------
    // Reset values and fixed options
    // ----------------------------------------
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;
    localparam logic HAS_USB_PLL = 1'b0;
    localparam logic [15:0] FAST_RC_KHZ = 16'h1f40;
    localparam int PLL_MULT_SHIFT = 2;
    // ----------------------------------------
    // Monitor timing in slow RC periods (31 kHz)
    // ----------------------------------------
    localparam int SLOW_RC_KHZ = 31;
    localparam int START_DELAY_US = 2000;
    localparam logic [6:0] START_DELAY_TICKS =
        7'((START_DELAY_US * SLOW_RC_KHZ + 999) / 1000);
    localparam logic [6:0] WINDOW_TICKS = 7'h04;
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {MON_IDLE, MON_HOLD, MON_DELAY, MON_WATCH} rcsfc_mon_t;
    typedef struct packed {
        logic [2:0] cur_src;
        logic [2:0] nxt_src;
        logic [2:0] div_sel;
        logic fail_flag;
        logic sw_req;
        logic init_done;
        rcsfc_mon_t mon;
        logic [6:0] tick_cnt;
        logic edge_seen;
        logic trap;
        logic [31:0] prdata;
        logic pslverr;
    } rcsfc_state_t;
    // Configuration straps grouped
    typedef struct packed {
        logic [1:0] switch_monitor_config;
        logic [2:0] initial_source_config;
        logic [1:0] primary_submode_config;
        logic wdt_enable;
        logic regulator_disable;
    } rcsfc_cfg_t;
endpackage : rcsfc_pkg

//--- testbench/tb_top.sv
// Self-checking bench for the clock source controller: APB master tasks and scenarios.
// Assumes rcsfc_ctrl with zero-wait APB and oscillator events as one-cycle pulses.
`timescale 1ns/10ps
module tb_top;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rcsfc_pkg::rcsfc_cfg_t cfg;
    logic power_up_timer_done, internal_system_reset, reset_event, sleep, er;
    logic slow_rc_tick, sys_clk_edge, source_ready, pll_lock;
    logic [2:0] sys_clk_sel;
    logic [3:0] postscale_shift;
    logic [15:0] sys_clk_nominal_khz;
    logic fast_rc_enable, slow_rc_enable, pll_enable, usb_clk_enable, clock_fail_trap;
    int bad_count = 0;
    int tests_run = 0;
    int traps = 0;
    int t0;
    rcsfc_ctrl u_rcsfc_ctrl (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .power_up_timer_done(power_up_timer_done),
        .internal_system_reset(internal_system_reset), .reset_event(reset_event),
        .sleep(sleep), .slow_rc_tick(slow_rc_tick), .sys_clk_edge(sys_clk_edge),
        .source_ready(source_ready), .pll_lock(pll_lock), .sys_clk_sel(sys_clk_sel),
        .postscale_shift(postscale_shift), .sys_clk_nominal_khz(sys_clk_nominal_khz),
        .fast_rc_enable(fast_rc_enable), .slow_rc_enable(slow_rc_enable),
        .pll_enable(pll_enable), .usb_clk_enable(usb_clk_enable),
        .clock_fail_trap(clock_fail_trap));
    // ----------------------------------------
    // Clock, trap counter, helpers
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (clock_fail_trap === 1'b1)
            traps <= traps + 1;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                er = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle keeps back-to-back calls from reassigning psel in one step
        @(posedge clk);
    endtask : apb
    task automatic tick(input int n);
        repeat (n)
        begin
            slow_rc_tick <= 1'b1;
            @(posedge clk);
            slow_rc_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : tick
    task automatic do_reset(input rcsfc_pkg::rcsfc_cfg_t c);
        cfg <= c;
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic switch_to(input logic [2:0] s);
        apb(1'b1, rcsfc_pkg::OSC_CTRL_ADDR, {20'h0_0000, 1'b0, s, 8'h01});
        for (int i = 0; i < 20 && sys_clk_sel !== s; i++)
            @(posedge clk);
        chk("current source", {29'h0, s}, {29'h0, sys_clk_sel});
    endtask : switch_to
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_divide;
        chk("divided mode", 32'h0000_0007, {29'h0, sys_clk_sel});
        chk("fast rc on", 32'h0000_0001, {31'h0, fast_rc_enable});
        for (int d = 0; d < 8; d++)
        begin
            apb(1'b1, rcsfc_pkg::CLK_DIV_ADDR, 32'(d) << 8);
            apb(1'b0, rcsfc_pkg::CLK_DIV_ADDR, 32'h0000_0000);
            chk("divide field", 32'(d), {29'h0, rd[10:8]});
            chk("shift", (d == 7) ? 32'h8 : 32'(d), {28'h0, postscale_shift});
            chk("nominal", 32'(8000 >> ((d == 7) ? 8 : d)), {16'h0, sys_clk_nominal_khz});
        end
    endtask : t_divide
    task automatic t_pll;
        switch_to(3'h1);
        for (int d = 0; d < 3; d++)
        begin
            apb(1'b1, rcsfc_pkg::CLK_DIV_ADDR, 32'(d) << 8);
            @(posedge clk);
            chk("pll on", (d < 2) ? 32'h1 : 32'h0, {31'h0, pll_enable});
            chk("pll nominal", (d == 0) ? 32'd32000 : (d == 1) ? 32'd16000 : 32'h0,
                {16'h0, sys_clk_nominal_khz});
            chk("usb clock", 32'h0000_0000, {31'h0, usb_clk_enable});
        end
        apb(1'b1, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0101);
        repeat (3) @(posedge clk);
        apb(1'b0, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0000);
        chk("redundant request", 32'h0000_0000, {31'h0, rd[0]});
        chk("redundant current", 32'h0000_0001, {29'h0, rd[14:12]});
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, er});
        chk("unmapped data", 32'h0000_0000, rd);
    endtask : t_pll
    task automatic t_fail;
        source_ready <= 1'b0;
        apb(1'b1, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0201);
        sys_clk_edge <= 1'b0;
        t0 = traps;
        for (int i = 0; i < 9 && traps == t0; i++)
            tick(1);
        sys_clk_edge <= 1'b1;
        chk("fail trap", 32'h1, 32'(traps - t0));
        chk("fallback", 32'h0000_0000, {29'h0, sys_clk_sel});
        apb(1'b0, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0000);
        chk("fail flag", 32'h0000_0001, {31'h0, rd[3]});
        chk("request cleared", 32'h0000_0000, {31'h0, rd[0]});
        chk("slow rc kept", 32'h0000_0001, {31'h0, slow_rc_enable});
    endtask : t_fail
    task automatic t_delay;
        source_ready <= 1'b1;
        switch_to(3'h5);
        source_ready <= 1'b0;
        reset_event <= 1'b1;
        internal_system_reset <= 1'b1;
        @(posedge clk);
        reset_event <= 1'b0;
        repeat (3) @(posedge clk);
        internal_system_reset <= 1'b0;
        @(posedge clk);
        t0 = traps;
        tick(61);
        chk("early trap", 32'h0, 32'(traps - t0));
        tick(1);
        chk("delay trap", 32'h1, 32'(traps - t0));
        chk("delay fallback", 32'h0000_0000, {29'h0, sys_clk_sel});
    endtask : t_delay
    task automatic t_disabled;
        power_up_timer_done <= 1'b0;
        do_reset({2'b10, rcsfc_pkg::SRC_PRIMARY, rcsfc_pkg::SUB_HIGH_XTAL, 1'b0, 1'b1});
        chk("initial source", 32'h2, {29'h0, sys_clk_sel});
        chk("fast rc at por", 32'h1, {31'h0, fast_rc_enable});
        chk("slow rc at por", 32'h1, {31'h0, slow_rc_enable});
        power_up_timer_done <= 1'b1;
        repeat (2) @(posedge clk);
        chk("fast rc off", 32'h0, {31'h0, fast_rc_enable});
        chk("slow rc off", 32'h0, {31'h0, slow_rc_enable});
        apb(1'b1, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0701);
        repeat (3) @(posedge clk);
        apb(1'b0, rcsfc_pkg::OSC_CTRL_ADDR, 32'h0000_0000);
        chk("request held low", 32'h0, {31'h0, rd[0]});
        chk("next ignored", 32'h2, {29'h0, sys_clk_sel});
        sys_clk_edge <= 1'b0;
        t0 = traps;
        tick(8);
        chk("monitor off", 32'h0, 32'(traps - t0));
    endtask : t_disabled
    // ----------------------------------------
    // Main sequence, watchdog, verdict
    // ----------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, sleep, slow_rc_tick, reset_event} = '0;
        {power_up_timer_done, internal_system_reset} = 2'b10;
        {sys_clk_edge, source_ready, pll_lock} = 3'b111;
        cfg = '0;
        sys_rst = 1'b1;
        do_reset({2'b00, rcsfc_pkg::SRC_FAST_RC_DIV, rcsfc_pkg::SUB_HIGH_XTAL, 1'b1, 1'b0});
        t_divide();
        t_pll();
        t_fail();
        t_delay();
        t_disabled();
        results();
    end
    initial
    begin
        #500_000;
        bad_count++;
        results();
    end
endmodule : tb_top
